// ### inc/scbpc_cfg.svh
// register offsets, field positions and sizes for the switched-cap type b control block
`ifndef SCBPC_CFG_SVH
`define SCBPC_CFG_SVH
`define SCBPC_OFS_BLK11 12'h084
`define SCBPC_OFS_BLK13 12'h08C
`define SCBPC_OFS_BLK20 12'h090
`define SCBPC_OFS_BLK22 12'h098
`define SCBPC_OFS_GLOBAL 12'h0A0
`define SCBPC_OFS_STATUS 12'h0A4
`define SCBPC_BANK_BIT 8
`define SCBPC_BIT_FB_SIZE 7
`define SCBPC_BIT_SWAP 6
`define SCBPC_BIT_SIGN 5
`define SCBPC_CAP_MSB 4
`define SCBPC_BIT_SAMPLE_HOLD_DISABLE 6
`define SCBPC_CTRL_RESET 8'h00
`define SCBPC_FB_UNITS_SMALL 6'h10
`define SCBPC_FB_UNITS_LARGE 6'h20
`define SCBPC_NUM_BLOCKS 4
`endif

// ### inc/scbpc_pkg.sv
// types shared by the switched-cap type b control block
package scbpc_pkg;
    typedef logic [7:0] scbpc_ctrl_t;
    typedef enum logic [1:0]
    {
        SCBPC_PH_ONE = 2'b01,
        SCBPC_PH_TWO = 2'b10
    } scbpc_phase_e;
endpackage

// ### rtl/scbpc_edge.sv
// rising and falling edge detector for one sampled phase clock
`timescale 1ns/100ps
module scbpc_edge
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev <= 1'b0;
        else if (ce)
            prev <= level;
    end

    assign rise = ce & level & ~prev;
    assign fall = ce & ~level & prev;
endmodule

// ### rtl/scbpc_lane.sv
// per-block phase mapping, output bus gating and comparator latch
`include "scbpc_cfg.svh"
`timescale 1ns/100ps
module scbpc_lane
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] ctrl,
    input wire logic sample_hold_disable,
    input wire logic ext_phase_one,
    input wire logic ext_phase_two,
    input wire logic ext_phase_two_late,
    input wire logic comp_in,
    output logic int_phase_one,
    output logic int_phase_two,
    output logic sample_input,
    output logic sample_reference,
    output logic out_bus_connect,
    output logic column_comparator_bus
);
    logic swap;
    logic one_rise, one_fall, two_rise, two_fall;
    logic captured;

    assign swap = ctrl[`SCBPC_BIT_SWAP];
    // internal phases follow external ones, swapped on request
    assign int_phase_one = swap ? ext_phase_two : ext_phase_one;
    assign int_phase_two = swap ? ext_phase_one : ext_phase_two;
    // input sampled on phase one unless the sign bit moves it
    assign sample_input = ctrl[`SCBPC_BIT_SIGN] ? int_phase_two : int_phase_one;
    assign sample_reference = ctrl[`SCBPC_BIT_SIGN] ? int_phase_one : int_phase_two;
    // drive the output bus in the late half of phase two only, or all of it
    assign out_bus_connect = (swap | sample_hold_disable) ? int_phase_two
                           : (int_phase_two & ext_phase_two_late);

    scbpc_edge u_one
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .level(ext_phase_one),
        .rise(one_rise),
        .fall(one_fall)
    );

    scbpc_edge u_two
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .level(ext_phase_two),
        .rise(two_rise),
        .fall(two_fall)
    );

    // capture on a falling phase, present on the rising other phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            captured <= 1'b0;
        else if (ce && (swap ? one_fall : two_fall))
            captured <= comp_in;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            column_comparator_bus <= 1'b0;
        else if (ce && (swap ? two_rise : one_rise))
            column_comparator_bus <= captured;
    end
endmodule

// ### rtl/scbpc_top.sv
// apb control registers for four switched-cap type b blocks and their phase logic
//
// Contract
// - The feedback size bit selects 16 capacitor units when clear and 32 when set.
// - With swap clear internal phase one is external phase one, with swap set it is phase two.
// - Normally the output bus is driven only during the second half of phase two.
// - With swap set the output bus is driven for the whole of phase two.
// - The global sample-hold disable drives every enabled output for all of phase two.
// - The comparator is captured on one falling phase and shown on the other rising phase.
// - Swap clear captures on falling phase two and shows on rising phase one, set reverses it.
// - Sign clear samples input on phase one and reference on phase two, set swaps them.
// - The five-bit input cap field selects 0 to 31 unit capacitors in binary.
// - Feedback size is bit 7, swap bit 6, sign bit 5 and input cap size bits 4 to 0.
// - Four block registers sit at distinct addresses, identical in both banks.
// - The latched comparator value drives the column comparator bus.
`include "scbpc_cfg.svh"
`timescale 1ns/100ps
module scbpc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_phase_one,
    input wire logic ext_phase_two,
    input wire logic ext_phase_two_late,
    input wire logic [3:0] comp_in,
    output logic [3:0] int_phase_one,
    output logic [3:0] int_phase_two,
    output logic [3:0] sample_input,
    output logic [3:0] sample_reference,
    output logic [3:0] out_bus_connect,
    output logic [3:0] column_comparator_bus,
    output logic [23:0] input_cap_size,
    output logic [23:0] feedback_units
);
    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    scbpc_pkg::scbpc_ctrl_t ctrl [4];
    logic sample_hold_disable;
    logic [11:0] word_addr;
    logic [3:0] hit;
    logic hit_global, hit_status, mapped, wr;

    // bank bit ignored so each register looks the same in both banks
    assign word_addr = paddr & ~(12'h001 << `SCBPC_BANK_BIT);
    assign hit[0] = word_addr == `SCBPC_OFS_BLK11;
    assign hit[1] = word_addr == `SCBPC_OFS_BLK13;
    assign hit[2] = word_addr == `SCBPC_OFS_BLK20;
    assign hit[3] = word_addr == `SCBPC_OFS_BLK22;
    assign hit_global = word_addr == `SCBPC_OFS_GLOBAL;
    assign hit_status = word_addr == `SCBPC_OFS_STATUS;
    assign mapped = (|hit) | hit_global | hit_status;
    assign wr = ce & psel & penable & pwrite & mapped & pstrb[0];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SCBPC_NUM_BLOCKS; gi++)
        begin : g_blk
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ctrl[gi] <= `SCBPC_CTRL_RESET;
                else if (wr && hit[gi])
                    ctrl[gi] <= pwdata[7:0];
            end

            // binary count of input capacitor units
            assign input_cap_size[gi*6 +: 6] = {1'b0, ctrl[gi][`SCBPC_CAP_MSB:0]};
            assign feedback_units[gi*6 +: 6] = ctrl[gi][`SCBPC_BIT_FB_SIZE]
                ? `SCBPC_FB_UNITS_LARGE : `SCBPC_FB_UNITS_SMALL;

            scbpc_lane u_lane
            (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .ctrl(ctrl[gi]),
                .sample_hold_disable(sample_hold_disable),
                .ext_phase_one(ext_phase_one),
                .ext_phase_two(ext_phase_two),
                .ext_phase_two_late(ext_phase_two_late),
                .comp_in(comp_in[gi]),
                .int_phase_one(int_phase_one[gi]),
                .int_phase_two(int_phase_two[gi]),
                .sample_input(sample_input[gi]),
                .sample_reference(sample_reference[gi]),
                .out_bus_connect(out_bus_connect[gi]),
                .column_comparator_bus(column_comparator_bus[gi])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_hold_disable <= 1'b0;
        else if (wr && hit_global)
            sample_hold_disable <= pwdata[`SCBPC_BIT_SAMPLE_HOLD_DISABLE];
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            for (int i = 0; i < `SCBPC_NUM_BLOCKS; i++)
                if (hit[i])
                    prdata <= {24'h00_0000, ctrl[i]};
            if (hit_global)
                prdata <= {25'h000_0000, sample_hold_disable, 6'h00};
            if (hit_status)
                prdata <= {28'h000_0000, column_comparator_bus};
        end
    end
endmodule

// ### verif/scbpc_properties.sv
// port assertions for the switched-cap type b control block
`timescale 1ns/100ps
module scbpc_properties
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_phase_one,
    input wire logic ext_phase_two,
    input wire logic ext_phase_two_late,
    input wire logic [3:0] int_phase_one,
    input wire logic [3:0] int_phase_two,
    input wire logic [3:0] sample_input,
    input wire logic [3:0] sample_reference,
    input wire logic [3:0] out_bus_connect,
    input wire logic [3:0] column_comparator_bus,
    input wire logic [23:0] input_cap_size,
    input wire logic [23:0] feedback_units
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rst; $rose(presetn) |-> input_cap_size == '0 && feedback_units == 24'h410410;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_cap; (input_cap_size & 24'h820820) == '0; endproperty
    a_cap: assert property (p_cap) else $error("bad cap");
    property p_fb; feedback_units[5:0] == 6'h10 || feedback_units[5:0] == 6'h20; endproperty
    a_fb: assert property (p_fb) else $error("bad feedback");
    property p_ph; ((int_phase_one ^ {4{ext_phase_one}})
        & (int_phase_one ^ {4{ext_phase_two}})) == '0; endproperty
    a_ph: assert property (p_ph) else $error("bad phase");
    property p_smp; (sample_input | sample_reference) == (int_phase_one | int_phase_two);
    endproperty
    a_smp: assert property (p_smp) else $error("bad sampling");
    property p_obc; (out_bus_connect & ~int_phase_two) == '0; endproperty
    a_obc: assert property (p_obc) else $error("bus outside phase");
    property p_late; (int_phase_two & ~out_bus_connect & {4{ext_phase_two_late}}) == '0;
    endproperty
    a_late: assert property (p_late) else $error("bus open late");
    property p_cmp; $changed(column_comparator_bus) |->
        (ext_phase_one && !$past(ext_phase_one, 2)) || (ext_phase_two && !$past(ext_phase_two, 2));
    endproperty
    a_cmp: assert property (p_cmp) else $error("latch moved");
endmodule

// ### verif/scbpc_tb.sv
// self-checking bench for the switched-cap type b control block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module scbpc_tb;
    logic pclk = '0, presetn = '0, ce = '1, psel = '0, penable = '0, pwrite = '0, err;
    logic ext_phase_one = '0, ext_phase_two = '0, ext_phase_two_late = '0, sw, sg, sh;
    logic pready, pslverr;
    logic [7:0] cfg;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h00012254;
    logic [3:0] pstrb = '0, comp_in = '0, cur = '0, prev, int_phase_one, int_phase_two;
    logic [3:0] sample_input, sample_reference, out_bus_connect, column_comparator_bus;
    logic [23:0] input_cap_size, feedback_units;
    logic [11:0] ofs [4] = '{12'h084, 12'h08C, 12'h090, 12'h098};
    int errors = 0, check_count = 0, i, k;
    scbpc_top dut (.*);
    always #4 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk);
        penable <= '1;
        do @(posedge pclk); while (pready !== '1);
        rd = prdata;
        err = pslverr;
        psel <= '0;
        penable <= '0;
    endtask
    // p holds phase one, phase two and the late half of phase two
    task automatic step(input logic [2:0] p);
        @(posedge pclk);
        {ext_phase_one, ext_phase_two, ext_phase_two_late, comp_in} <= {p, cur};
        @(posedge pclk);
        @(negedge pclk);
        `CHK(int_phase_one, {4{p[sw ? 1 : 2]}})
        `CHK(int_phase_two, {4{p[sw ? 2 : 1]}})
        `CHK(sample_reference, {4{p[sg ^ sw ? 2 : 1]}})
        `CHK(sample_input, {4{p[sg ^ sw ? 1 : 2]}})
        `CHK(out_bus_connect, {4{p[sw ? 2 : 1] & (sw | sh | p[0])}})
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= '1;
        pstrb <= 4'hF;
        for (i = 0; i < 5; i++)
        begin
            apb('0, i < 4 ? ofs[i] : 12'h0A8, rnd());
            `CHK({err, rd}, {i > 3, 32'h0})
        end
        for (k = 0; k < 16; k++)
        begin
            cfg = k < 2 ? {8{k[0]}} : 8'(rnd());
            apb('1, ofs[k % 4], {24'(rnd()), cfg});
            apb('0, ofs[k % 4] | 12'h100, '0);
            `CHK(rd, {24'h0, cfg})
            `CHK(input_cap_size[k % 4 * 6 +: 6], {1'h0, cfg[4:0]})
            `CHK(feedback_units[k % 4 * 6 +: 6], cfg[7] ? 6'h20 : 6'h10)
        end
        for (i = 0; i < 8; i++)
        begin
            {sh, sw, sg} = 3'(i);
            apb('1, 12'h0A0, {25'h0, sh, 6'h0});
            apb('0, 12'h1A0, '0);
            `CHK(rd, {25'h0, sh, 6'h0})
            for (k = 0; k < 4; k++)
                apb('1, ofs[k], {25'h0, sw, sg, 5'(rnd())});
            for (k = 0; k < 5; k++)
            begin
                prev = cur;
                cur = 4'(rnd());
                step(3'h4);
                step(3'h0);
                step(3'h2);
                step(3'h3);
                step(3'h0);
                if (k > 1)
                begin
                    `CHK(column_comparator_bus, sw ? cur : prev)
                    apb('0, 12'h0A4, '0);
                    `CHK(rd, {28'h0, sw ? cur : prev})
                end
            end
        end
        // a write while the clock enable is low must not land
        apb('1, ofs[0], 32'h0000_005A);
        ce <= '0;
        apb('1, ofs[0], 32'h0000_00FF);
        ce <= '1;
        apb('0, ofs[0], '0);
        `CHK(rd, 32'h0000_005A)
        // reset again in mid-run and look for cleared fields
        @(posedge pclk);
        presetn <= '0;
        @(posedge pclk);
        presetn <= '1;
        apb('0, ofs[0], '0);
        `CHK(rd, 32'h0)
        `CHK(feedback_units, 24'h410410)
        apb('0, 12'h0A0, '0);
        `CHK(rd, 32'h0)
        complete_run();
    end
    initial
    begin
        #20000;
        errors++;
        complete_run();
    end
endmodule
bind scbpc_top scbpc_properties chk (.*);
